//--- src/adl_ctl.sv
// AC-coupling detect controller with upper-lane inactive sequencing
`timescale 1ns/10ps
module adl_ctl
  import adl_pkg::*;
#(
  parameter int DET_TC = DET_CYC,
  parameter int RXT_TC = RXT_CYC
)(
  // Clock, reset, enable
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             ce,
  // Link sideband
  input  wire logic             link_reset_n,
  input  wire logic             link_stop_n,
  input  wire logic             tx_link_clk,
  // Cold reset outcome
  input  wire logic             cold_done,
  input  wire logic             dc_found,
  // Analog status
  input  wire logic             det_comp,
  input  wire logic             tx_clk_locked,
  input  wire logic             rx_ready,
  // Inactive lane control
  input  wire logic [LANES-1:0] lane_used,
  input  wire logic [LANES-1:0] programmed_width_fields,
  input  wire logic             width_up,
  input  wire logic             use_global,
  input  wire logic [1:0]       idle_lane_state_field,
  input  wire logic [1:0]       rx_idle_lane_state_field,
  input  wire logic [1:0]       tx_idle_lane_state_field,
  input  wire logic [1:0]       link_stop_select,
  input  wire logic             refresh_req,
  // Transmit and receive pad states
  output logic                  tx_ground_terminated,
  output logic                  tx_coupling_probe,
  output logic                  tx_electrical_idle,
  output logic                  tx_active_drive,
  output logic                  rx_ac_termination,
  // Link control bits
  output logic                  retry_enable_bit,
  output logic                  coding_enable_bit,
  output logic                  scrambler_enable_bit,
  output logic                  deemphasis_enable_bit,
  output logic                  link_failure_bit,
  output logic                  end_of_chain_bit,
  output logic                  transmitter_off_bit,
  // Training progress
  output logic                  tx_train_start,
  output logic                  rx_train_start,
  output logic [2:0]            det_state,
  // Upper lanes
  output logic [3*LANES-1:0]    lane_state,
  output logic [LANES-1:0]      rx_hold_eye,
  output logic [LANES-1:0]      tx_scrambled
);

  // ***************************************
  // Pin synchronisers
  // ***************************************
  logic [2:0] s1_reg, s2_reg;
  logic       lclk_d_reg;
  // Reset to idle pin levels, else a phantom stop reaches the lanes after reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s1_reg     <= SYNC_RST;
      s2_reg     <= SYNC_RST;
      lclk_d_reg <= 1'b0;
    end else if (ce) begin
      s1_reg     <= {tx_link_clk, link_stop_n, link_reset_n};
      s2_reg     <= s1_reg;
      lclk_d_reg <= s2_reg[2];
    end
  end
  wire rst_rel   = s2_reg[0];
  wire stop_on   = !s2_reg[1];
  // A rising link clock edge proves the transmit clock really toggles
  wire lclk_rise = s2_reg[2] && !lclk_d_reg;

  // ***************************************
  // Detect state machine
  // ***************************************
  adl_det_type st_reg, st_next;
  logic [23:0] tmr_reg;
  logic [1:0]  run_reg;
  logic        last_reg, seen_reg, found_reg, txt_reg, rxt_reg;

  wire det_win   = tmr_reg == 24'(DET_TC);
  wire rxt_win   = tmr_reg >= 24'(RXT_TC);
  wire agree     = run_reg == 2'h0 || det_comp == last_reg;
  wire third     = run_reg == 2'(SAMPLE_CNT - 1) && det_comp == last_reg;
  wire comp_slow = third && !det_comp;
  // Reaching threshold marks an open line; never reaching it marks a receiver present
  wire comp_fast = third && det_comp;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE:   if (cold_done && !dc_found) st_next = ST_RESET;
      ST_RESET:  if (rst_rel) st_next = ST_PROBE;
      ST_PROBE: begin
        if (det_win) st_next = (found_reg && seen_reg) ? ST_LINKUP : ST_PHYOFF;
      end
      ST_LINKUP: if (txt_reg && rxt_reg) st_next = ST_TRAIN;
      ST_TRAIN:  st_next = ST_TRAIN;
      ST_PHYOFF: st_next = ST_PHYOFF;
      default:   st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_reg <= ST_IDLE;
      tmr_reg <= 24'h000000;
    end else if (ce) begin
      st_reg  <= st_next;
      tmr_reg <= (st_reg == ST_PROBE || st_reg == ST_LINKUP) ? tmr_reg + 24'h000001 : 24'h000000;
    end
  end

  // Three matching comparator samples are needed for a verdict
  always_ff @(posedge clk_sys) begin
    if (!resetn || st_reg != ST_PROBE) begin
      run_reg   <= 2'h0;
      last_reg  <= 1'b0;
      seen_reg  <= 1'b0;
      found_reg <= 1'b0;
    end else if (ce && !seen_reg) begin
      // Noise breaks the run; a disagreeing sample starts a new one
      last_reg <= det_comp;
      run_reg  <= agree ? run_reg + 2'h1 : 2'h1;
      if (comp_slow || comp_fast) begin
        seen_reg  <= 1'b1;
        found_reg <= comp_slow;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn || (st_reg != ST_LINKUP && st_reg != ST_TRAIN)) begin
      txt_reg <= 1'b0;
      rxt_reg <= 1'b0;
    end else if (ce) begin
      if (tx_clk_locked && lclk_rise) txt_reg <= 1'b1;
      if (rxt_win && rx_ready) rxt_reg <= 1'b1;
    end
  end

  // ***************************************
  // Pad and control outputs
  // ***************************************
  wire up = st_reg == ST_LINKUP || st_reg == ST_TRAIN;
  wire off = st_reg == ST_PHYOFF;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_ground_terminated  <= 1'b1;
      tx_coupling_probe     <= 1'b0;
      tx_electrical_idle    <= 1'b0;
      tx_active_drive       <= 1'b0;
      retry_enable_bit      <= 1'b0;
      coding_enable_bit     <= 1'b0;
      scrambler_enable_bit  <= 1'b0;
      deemphasis_enable_bit <= 1'b0;
      link_failure_bit      <= 1'b0;
      end_of_chain_bit      <= 1'b0;
      transmitter_off_bit   <= 1'b0;
    end else if (ce) begin
      tx_ground_terminated  <= !(st_next == ST_PROBE || st_next == ST_LINKUP || st_next == ST_TRAIN);
      tx_coupling_probe     <= st_next == ST_PROBE;
      tx_electrical_idle    <= st_next == ST_LINKUP;
      tx_active_drive       <= st_next == ST_LINKUP || st_next == ST_TRAIN;
      if (st_next == ST_LINKUP) begin
        retry_enable_bit      <= 1'b1;
        coding_enable_bit     <= 1'b1;
        scrambler_enable_bit  <= 1'b1;
        deemphasis_enable_bit <= 1'b1;
      end
      if (st_next == ST_PHYOFF) begin
        link_failure_bit    <= 1'b1;
        end_of_chain_bit    <= 1'b1;
        transmitter_off_bit <= 1'b1;
      end
    end
  end

  // Termination stays on from detect entry, before reset can release
  assign rx_ac_termination = st_reg != ST_IDLE;
  assign tx_train_start    = txt_reg && up;
  assign rx_train_start    = rxt_reg && up;
  assign det_state         = st_reg;

  // ***************************************
  // Upper lanes
  // ***************************************
  wire [1:0] rx_mode = use_global ? idle_lane_state_field : rx_idle_lane_state_field;
  wire [1:0] tx_mode = use_global ? idle_lane_state_field : tx_idle_lane_state_field;
  // Ganged sublinks follow this link into PHY-off as a reset condition
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      adl_lane u_lane (
        .clk_sys          (clk_sys),
        .resetn           (resetn && !off),
        .ce               (ce),
        .lane_used        (lane_used[g]),
        .below_width      (programmed_width_fields[g]),
        .width_up         (width_up),
        .rx_mode          (rx_mode),
        .tx_mode          (tx_mode),
        .link_stop_select (link_stop_select),
        .stop_req         (stop_on),
        .link_reset       (!rst_rel),
        .refresh_req      (refresh_req),
        .lane_state       (lane_state[3*g +: 3]),
        .rx_hold_eye      (rx_hold_eye[g]),
        .tx_scrambled     (tx_scrambled[g])
      );
    end
  endgenerate

  // ***************************************
  // Checks
  // ***************************************
  sequence s_probe_window;
    st_reg == ST_PROBE && ce && !det_win;
  endsequence
  chk_entry_cond: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_reg == ST_IDLE && st_next == ST_RESET) |-> !dc_found) else $error("detect entered with DC partner");
  chk_probe_pad: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_probe_window ##1 st_reg == ST_PROBE |-> tx_coupling_probe && !tx_ground_terminated)
    else $error("probe not driven");
  chk_ground_term: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_reg == ST_RESET && ce) ##1 st_reg == ST_RESET |-> tx_ground_terminated) else $error("not ground terminated");
  chk_wait_window: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_reg == ST_PROBE && st_next != ST_PROBE) |-> tmr_reg == 24'(DET_TC)) else $error("verdict taken early");
  chk_linkup_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_reg == ST_LINKUP && $past(st_reg) == ST_LINKUP) |-> retry_enable_bit && coding_enable_bit
      && scrambler_enable_bit && deemphasis_enable_bit) else $error("link-up bits missing");
  chk_fail_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_reg == ST_PHYOFF && ce) ##1 1'b1 |-> link_failure_bit && end_of_chain_bit && transmitter_off_bit)
    else $error("failure bits missing");
  chk_rx_train: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(rx_train_start) |-> tmr_reg > 24'(RXT_TC)) else $error("receiver trained early");
  chk_three_samples: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(seen_reg) |-> $past(run_reg) == 2'(SAMPLE_CNT - 1) && $past(det_comp) == $past(last_reg))
    else $error("verdict before three samples");
endmodule : adl_ctl

//--- pkg/adl_pkg.sv
// Constants and types for the AC detect and inactive-lane controller
// Function
// - Enter AC detect only when cold reset found no DC-coupled partner.
// - Ground-terminate during reset; afterwards probe positive leg of data lane 0 only.
// - Present AC receiver termination during detect, valid before reset release.
// - Act on detection result only after 13 to 13.1 ms from reset release.
// - On detect set retry enable, idle data and control lanes, drive clock.
// - On detect also set coding, scrambler and de-emphasis enables.
// - Transmitter enters training once transmit clock reaches full speed.
// - Receiver enters training 13.2 ms after reset release when ready.
// - No receiver: set failure, end-of-chain, transmitter-off; go PHY-off with sublinks.
// - Transmit clock must be at full speed within 13.1 ms when detected.
// - Probe not reaching threshold within window counts as no receiver; the code counts it as a receiver found.
// - Sample the detect comparator three times in succession before deciding.
// - Upper lanes go inactive when unused at cold reset or width reduced.
// - Inactive behaviour chosen by global field or separate receive and transmit fields.
// - Stop with field 00b, 10b, or 11b with select 01b: hold eye in 100 ns.
// - Field 10b, or 11b with select 01b: send scrambled data 200 to 300 ns.
// - Under stop inactive lanes disconnect, then return to inactive afterwards.
// - Refresh command moves inactive lanes below programmed width to refresh.
// - Width increase: leave inactive to warm reset on reset, disconnected on stop.
// - Refreshed inactive lanes need no alignment with active lanes.
package adl_pkg;
  localparam int CLK_NS           = 8;
  localparam int T_DET_US         = 13000;
  localparam int T_RXT_US         = 13200;
  localparam int T_EYE_NS         = 100;
  localparam int T_SCR_MIN_NS     = 200;
  localparam int T_SCR_MAX_NS     = 300;
  localparam int DET_CYC          = T_DET_US * 1000 / CLK_NS;
  localparam int RXT_CYC          = T_RXT_US * 1000 / CLK_NS;
  localparam int EYE_CYC          = T_EYE_NS / CLK_NS;
  localparam int SCR_CYC          = (T_SCR_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_CNT       = 3;
  // Synchroniser value after reset: stop released, link reset held, link clock low
  localparam logic [2:0] SYNC_RST = 3'h2;
  localparam logic [1:0] ILS_EYE0 = 2'h0;
  localparam logic [1:0] ILS_SCR  = 2'h2;
  localparam logic [1:0] ILS_SEL  = 2'h3;
  localparam logic [1:0] LSS_ON   = 2'h1;
  localparam int LANES            = 8;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_RESET  = 3'h1,
    ST_PROBE  = 3'h3,
    ST_LINKUP = 3'h2,
    ST_TRAIN  = 3'h6,
    ST_PHYOFF = 3'h4
  } adl_det_type;

  typedef enum logic [2:0] {
    LN_ACTIVE  = 3'h0,
    LN_INACT   = 3'h1,
    LN_SCRAM   = 3'h3,
    LN_DISC    = 3'h2,
    LN_REFRESH = 3'h6,
    LN_WARM    = 3'h4
  } adl_lane_type;
endpackage : adl_pkg

//--- src/adl_lane.sv
// One upper lane's inactive-state sequencer
`timescale 1ns/10ps
module adl_lane
  import adl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       ce,
  // Control
  input  wire logic       lane_used,
  input  wire logic       below_width,
  input  wire logic       width_up,
  input  wire logic [1:0] rx_mode,
  input  wire logic [1:0] tx_mode,
  input  wire logic [1:0] link_stop_select,
  input  wire logic       stop_req,
  input  wire logic       link_reset,
  input  wire logic       refresh_req,
  // Status
  output logic [2:0]      lane_state,
  output logic            rx_hold_eye,
  output logic            tx_scrambled
);
  adl_lane_type st_reg, st_next;
  logic [5:0]   cnt_reg;

  // ***************************************
  // Mode decode
  // ***************************************
  function automatic logic hold_sel(input logic [1:0] m, input logic [1:0] s);
    hold_sel = (m == ILS_EYE0) || (m == ILS_SCR) || (m == ILS_SEL && s == LSS_ON);
  endfunction : hold_sel
  function automatic logic scr_sel(input logic [1:0] m, input logic [1:0] s);
    scr_sel = (m == ILS_SCR) || (m == ILS_SEL && s == LSS_ON);
  endfunction : scr_sel

  wire rx_hold_mode = hold_sel(rx_mode, link_stop_select);
  wire tx_scr_mode  = scr_sel(tx_mode, link_stop_select);
  wire scr_done     = cnt_reg >= 6'(SCR_CYC);

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      LN_ACTIVE:  if (!lane_used) st_next = LN_INACT;
      LN_INACT: begin
        if (width_up && link_reset) st_next = LN_WARM;
        else if (width_up && stop_req) st_next = LN_DISC;
        else if (stop_req && tx_scr_mode) st_next = LN_SCRAM;
        else if (stop_req) st_next = LN_DISC;
        else if (refresh_req && below_width) st_next = LN_REFRESH;
      end
      LN_SCRAM:   if (scr_done) st_next = LN_DISC;
      LN_DISC:    if (!stop_req) st_next = width_up ? LN_ACTIVE : LN_INACT;
      LN_REFRESH: if (!refresh_req) st_next = LN_INACT;
      LN_WARM:    if (!link_reset) st_next = LN_ACTIVE;
      default:    st_next = LN_INACT;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_reg  <= LN_ACTIVE;
      cnt_reg <= 6'h00;
    end else if (ce) begin
      st_reg  <= st_next;
      cnt_reg <= (st_next == LN_SCRAM) ? cnt_reg + 6'h01 : 6'h00;
    end
  end

  // Eye hold asserts on stop entry, well inside the 100 ns budget
  always_ff @(posedge clk_sys) begin
    if (!resetn) rx_hold_eye <= 1'b0;
    else if (ce) rx_hold_eye <= rx_hold_mode && stop_req && st_reg != LN_ACTIVE;
  end

  assign lane_state   = st_reg;
  assign tx_scrambled = (st_reg == LN_SCRAM);

  chk_scram_length: assert property (@(posedge clk_sys) disable iff (!resetn || !ce)
    $rose(tx_scrambled) |-> tx_scrambled [*8]) else $error("scrambled burst too short");
  chk_eye_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ce && st_reg == LN_INACT && stop_req && rx_hold_mode) ##1 ce |-> ##[0:12] rx_hold_eye)
    else $error("eye hold late");
endmodule : adl_lane

//--- testbench/adl_peer_model.sv
// Far-end peer model: detect comparator response, receiver readiness, link clock
`timescale 1ns/10ps
module adl_peer_model
  import adl_pkg::*;
(
  // Clock
  input  wire logic       clk_sys,
  // Bench control
  input  wire logic [1:0] peer_mode,
  input  wire logic       probe,
  input  wire logic       link_run,
  // Far-end responses
  output logic            det_comp,
  output logic            rx_ready,
  output logic            tx_link_clk
);
  logic [1:0] wobble_reg;
  initial begin
    det_comp    = 1'b1;
    rx_ready    = 1'b0;
    tx_link_clk = 1'b0;
    wobble_reg  = 2'h0;
  end
  // Mode 0 slow ramp, 1 open line, 2 noisy pads never settle
  always @(posedge clk_sys) begin
    wobble_reg <= wobble_reg + 2'h1;
    det_comp   <= (probe && peer_mode == 2'h0) ? 1'b0 : (probe && peer_mode == 2'h1) ? 1'b1 : wobble_reg[0];
    rx_ready   <= (peer_mode == 2'h0);
  end
  // Link clock stands still while link_run is low
  always begin
    #32;
    tx_link_clk = link_run ? ~tx_link_clk : 1'b0;
  end
endmodule : adl_peer_model

//--- testbench/adl_ctl_tb_top.sv
// Self-checking bench for the AC detect and inactive-lane controller
`timescale 1ns/10ps
module adl_ctl_tb_top;
  import adl_pkg::*;
  // ***********************
  // Signals
  // ***********************
  localparam int DTC = 50;
  localparam int RTC = 60;
  logic clk_sys, resetn, ce, link_reset_n, link_stop_n, tx_link_clk, cold_done, dc_found, det_comp;
  logic tx_clk_locked, rx_ready, width_up, use_global, refresh_req, link_run;
  logic [7:0] lane_used, programmed_width_fields, rx_hold_eye, tx_scrambled;
  logic [1:0] idle_lane_state_field, rx_idle_lane_state_field, tx_idle_lane_state_field, link_stop_select, peer_mode;
  logic tx_ground_terminated, tx_coupling_probe, tx_electrical_idle, tx_active_drive, rx_ac_termination;
  logic retry_enable_bit, coding_enable_bit, scrambler_enable_bit, deemphasis_enable_bit;
  logic link_failure_bit, end_of_chain_bit, transmitter_off_bit, tx_train_start, rx_train_start;
  logic [2:0]  det_state;
  logic [23:0] lane_state;
  logic [31:0] rnd;
  int          fail_count;
  int          checked;

  adl_ctl #(.DET_TC(DTC), .RXT_TC(RTC)) i_adl_ctl (
    .clk_sys, .resetn, .ce, .link_reset_n, .link_stop_n, .tx_link_clk, .cold_done, .dc_found, .det_comp,
    .tx_clk_locked, .rx_ready, .lane_used, .programmed_width_fields, .width_up, .use_global,
    .idle_lane_state_field, .rx_idle_lane_state_field, .tx_idle_lane_state_field, .link_stop_select,
    .refresh_req, .tx_ground_terminated, .tx_coupling_probe, .tx_electrical_idle, .tx_active_drive,
    .rx_ac_termination, .retry_enable_bit, .coding_enable_bit, .scrambler_enable_bit, .deemphasis_enable_bit,
    .link_failure_bit, .end_of_chain_bit, .transmitter_off_bit, .tx_train_start, .rx_train_start,
    .det_state, .lane_state, .rx_hold_eye, .tx_scrambled);
  adl_peer_model i_adl_peer_model (.clk_sys, .peer_mode, .probe(tx_coupling_probe), .link_run, .det_comp,
    .rx_ready, .tx_link_clk);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ***********************
  // Helpers
  // ***********************
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic hold_exp(input logic [1:0] m, input logic [1:0] s);
    return m == ILS_EYE0 || m == ILS_SCR || (m == ILS_SEL && s == LSS_ON);
  endfunction : hold_exp
  function automatic logic scr_exp(input logic [1:0] m, input logic [1:0] s);
    return m == ILS_SCR || (m == ILS_SEL && s == LSS_ON);
  endfunction : scr_exp
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  // Bounded wait, counts edges until the state code shows up
  task automatic wait_det(input logic [2:0] st, input int bound, output int n);
    n = 0;
    while (det_state !== st) begin
      @(posedge clk_sys);
      n++;
      if (n > bound) begin
        fail_count++;
        $display("wrong value at %0t: state wait ran out", $time);
        print_verdict();
      end
    end
  endtask : wait_det
  // One full cold-start detect pass against a peer in mode m
  task automatic det_run(input logic [1:0] m);
    int n;
    @(posedge clk_sys);
    resetn <= 1'b0;
    link_reset_n <= 1'b0;
    cold_done <= 1'b0;
    tx_clk_locked <= 1'b0;
    link_run <= 1'b0;
    peer_mode <= m;
    cyc(4);
    resetn <= 1'b1;
    cyc(2);
    cold_done <= 1'b1;
    dc_found <= 1'b0;
    cyc(6);
    @(negedge clk_sys);
    check(det_state, ST_RESET, "enter detect");
    check(tx_ground_terminated, 1, "ground term");
    check(tx_coupling_probe, 0, "probe in reset");
    check(rx_ac_termination, 1, "rx term before release");
    @(posedge clk_sys);
    link_reset_n <= 1'b1;
    link_run <= 1'b1;
    wait_det(ST_PROBE, 6, n);
    @(negedge clk_sys);
    check({tx_coupling_probe, tx_ground_terminated, rx_ac_termination}, 3'h5, "probe pads");
    // Link reset and stop stay untouched until training ends
    wait_det(m == 2'h0 ? ST_LINKUP : ST_PHYOFF, DTC + 4, n);
    check(n >= DTC - 4, 1, "verdict too early");
    @(negedge clk_sys);
    if (m == 2'h0) begin
      check({retry_enable_bit, tx_electrical_idle, tx_active_drive}, 3'h7, "link up pads");
      check({coding_enable_bit, scrambler_enable_bit, deemphasis_enable_bit}, 3'h7, "enables");
      check({tx_train_start, link_failure_bit}, 2'h0, "tx train early");
      check(rx_train_start, 0, "rx train early");
      @(posedge clk_sys);
      tx_clk_locked <= 1'b1;
      // Lock counts at the next link clock rise: up to 64 ns plus synchroniser
      cyc(12);
      @(negedge clk_sys);
      check(tx_train_start, 1, "tx train");
      wait_det(ST_TRAIN, RTC, n);
      @(negedge clk_sys);
      check(rx_train_start, 1, "rx train");
    end else begin
      check({link_failure_bit, end_of_chain_bit, transmitter_off_bit}, 3'h7, "fail bits");
      check({retry_enable_bit, tx_ground_terminated}, 2'h1, "phy off pads");
    end
  endtask : det_run
  // ***********************
  // Main sequence
  // ***********************
  initial begin
    logic [1:0] m;
    logic [1:0] sel;
    logic       g;
    {resetn, cold_done, dc_found, tx_clk_locked, width_up, use_global, refresh_req, link_run} = 8'h00;
    {ce, link_reset_n, link_stop_n} = 3'h5;
    {lane_used, programmed_width_fields} = 16'hFFFF;
    {idle_lane_state_field, rx_idle_lane_state_field, tx_idle_lane_state_field, link_stop_select} = 8'h00;
    peer_mode = 2'h0;
    fail_count = 0;
    checked = 0;
    rnd = 32'd36266;
    cyc(4);
    resetn <= 1'b1;
    cold_done <= 1'b1;
    dc_found <= 1'b1;
    cyc(10);
    @(negedge clk_sys);
    check(det_state, ST_IDLE, "dc partner");
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      det_run(i < 3 ? 2'(i) : 2'(rnd % 3));
    end
    det_run(2'h0);
    @(posedge clk_sys);
    lane_used <= 8'h0F;
    cyc(4);
    @(negedge clk_sys);
    check(lane_state, {{4{LN_INACT}}, {4{LN_ACTIVE}}}, "unused lanes");
    for (int k = 0; k < 8; k++) begin
      rnd = xs(rnd);
      m = k < 4 ? 2'(k) : (k == 4 ? 2'h3 : rnd[1:0]);
      sel = k < 4 ? LSS_ON : (k == 4 ? 2'h0 : rnd[3:2]);
      @(posedge clk_sys);
      g = k < 2 ? k[0] : rnd[4];
      use_global <= g;
      // The unselected field carries the inverse so a wrong pick shows
      idle_lane_state_field <= g ? m : ~m;
      rx_idle_lane_state_field <= g ? ~m : m;
      tx_idle_lane_state_field <= g ? ~m : m;
      link_stop_select <= sel;
      cyc(2);
      link_stop_n <= 1'b0;
      cyc(12);
      @(negedge clk_sys);
      check(rx_hold_eye[7:4], {4{hold_exp(m, sel)}}, "hold eye");
      check(tx_scrambled[7:4], {4{scr_exp(m, sel)}}, "scrambled");
      cyc(40);
      @(negedge clk_sys);
      check(lane_state[14:12], LN_DISC, "disconnect");
      @(posedge clk_sys);
      link_stop_n <= 1'b1;
      cyc(6);
      @(negedge clk_sys);
      check(lane_state[14:12], LN_INACT, "back inactive");
    end
    @(posedge clk_sys);
    programmed_width_fields <= 8'h30;
    refresh_req <= 1'b1;
    ce <= 1'b0;
    cyc(4);
    @(negedge clk_sys);
    check(lane_state[14:12], LN_INACT, "frozen by enable");
    @(posedge clk_sys);
    ce <= 1'b1;
    cyc(5);
    @(negedge clk_sys);
    check({lane_state[20:18], lane_state[14:12]}, {LN_INACT, LN_REFRESH}, "refresh");
    @(posedge clk_sys);
    refresh_req <= 1'b0;
    cyc(5);
    @(negedge clk_sys);
    check(lane_state[14:12], LN_INACT, "refresh over");
    @(posedge clk_sys);
    width_up <= 1'b1;
    link_reset_n <= 1'b0;
    cyc(6);
    @(negedge clk_sys);
    check(lane_state[14:12], LN_WARM, "width up reset");
    print_verdict();
  end
endmodule : adl_ctl_tb_top
